/* rtl/pdc_pkg.sv */
// Package of register map, field positions, reset values and types for the power/downshift block.
// What this block does
// - Energy-detect power down is entered only while enable bit 3 of power_down_control is set, which it is after reset.
// - During energy-detect power down, link pulses keep going out only while bit 2 is set, which it is after reset.
// - Carrier sense is raised during own half-duplex transmissions only while bit 15 of carrier_downshift_control is set.
// - With downshift on, a failed 1000BASE-T negotiation falls back to 100BASE-TX then 10BASE-T as allowed, and the cycle repeats.
// - Any drop of an established link restarts the sequence at 1000BASE-T.
// - Mode field 11:10 decodes 00 off, 01 allow 10BASE-T, 10 allow 100BASE-TX, 11 allow both, reset 11.
// - Bit 7 is read-only, resets to 0, and shows whether 1000BASE-T next pages are under manual control.
// - Group management mode is active only while bit 6 is set, and it is clear after reset.
// - The transmit clock is driven onto the test clock pin only while bit 5 is set, clear after reset.
package pdc_pkg;
  localparam logic [4:0] PDC_ADDR_POWER = 5'h15;
  localparam logic [4:0] PDC_ADDR_CARRIER = 5'h16;
  localparam int PDC_BIT_EDPD_EN = 3;
  localparam int PDC_BIT_NLP_EN = 2;
  localparam int PDC_BIT_CRS_TX = 15;
  localparam int PDC_BIT_MODE_HI = 11;
  localparam int PDC_BIT_MODE_LO = 10;
  localparam int PDC_BIT_ALT_NP = 7;
  localparam int PDC_BIT_GROUP = 6;
  localparam int PDC_BIT_TCLK = 5;
  localparam logic [1:0] PDC_MODE_RESET = 2'h3;
  localparam logic [15:0] PDC_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PDC_SPEED_1000 = 2'b00,
    PDC_SPEED_100 = 2'b01,
    PDC_SPEED_10 = 2'b10
  } pdc_speed_type;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pdc_bus_type;

  typedef struct packed {
    logic an_fail;
    logic link_up;
    logic edpd_cond;
    logic tx_active;
    logic half_duplex;
    logic alt_np;
  } pdc_phy_in_type;
endpackage

/* rtl/pdc_downshift.sv */
// Speed downshift sequencer.
`timescale 1ns/1ps
`default_nettype none
module pdc_downshift
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] mode,
  input wire logic an_fail,
  input wire logic link_up,
  output pdc_speed_type speed
);
  logic link_was_up;
  pdc_speed_type next_speed;
  logic allow_100;
  logic allow_10;

  assign allow_100 = mode[1];
  assign allow_10 = mode[0];

  always_comb begin
    next_speed = speed;
    if (link_was_up && !link_up) begin
      next_speed = PDC_SPEED_1000;
    end else if (mode == 2'b00) begin
      next_speed = PDC_SPEED_1000;
    end else if (an_fail && !link_up) begin
      unique case (speed)
        PDC_SPEED_1000: next_speed = allow_100 ? PDC_SPEED_100 : PDC_SPEED_10;
        PDC_SPEED_100: next_speed = allow_10 ? PDC_SPEED_10 : PDC_SPEED_1000;
        PDC_SPEED_10: next_speed = PDC_SPEED_1000;
        default: next_speed = PDC_SPEED_1000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      speed <= PDC_SPEED_1000;
      link_was_up <= 1'b0;
    end else begin
      speed <= next_speed;
      link_was_up <= link_up;
    end
  end
endmodule
`default_nettype wire

/* rtl/pdc_top.sv */
// Top of the power-down and downshift control register bank.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pdc_top
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire pdc_bus_type bus,
  input wire pdc_phy_in_type phy,
  input wire logic tx_clock,
  output logic [15:0] rdata,
  output logic edpd_active,
  output logic nlp_send,
  output logic crs_out,
  output logic group_mode,
  output logic test_clock_out_pin,
  output logic test_clock_out_en,
  output pdc_speed_type speed_attempt
);
  logic edpd_en;
  logic nlp_en;
  logic crs_tx_en;
  logic [1:0] ds_mode;
  logic group_en;
  logic tclk_en;
  logic alt_np;
  pdc_speed_type speed;
  logic [15:0] power_view;
  logic [15:0] carrier_view;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edpd_en <= 1'b1;
      nlp_en <= 1'b1;
    end else if (bus.wr && bus.addr == PDC_ADDR_POWER) begin
      edpd_en <= bus.wdata[PDC_BIT_EDPD_EN];
      nlp_en <= bus.wdata[PDC_BIT_NLP_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crs_tx_en <= 1'b0;
      ds_mode <= PDC_MODE_RESET;
      group_en <= 1'b0;
      tclk_en <= 1'b0;
    end else if (bus.wr && bus.addr == PDC_ADDR_CARRIER) begin
      crs_tx_en <= bus.wdata[PDC_BIT_CRS_TX];
      ds_mode <= bus.wdata[PDC_BIT_MODE_HI:PDC_BIT_MODE_LO];
      group_en <= bus.wdata[PDC_BIT_GROUP];
      tclk_en <= bus.wdata[PDC_BIT_TCLK];
    end
  end

  // The next-page status is sampled from the core and never written.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      alt_np <= 1'b0;
    end else begin
      alt_np <= phy.alt_np;
    end
  end

  always_comb begin
    power_view = PDC_ZERO;
    power_view[PDC_BIT_EDPD_EN] = edpd_en;
    power_view[PDC_BIT_NLP_EN] = nlp_en;
    carrier_view = PDC_ZERO;
    carrier_view[PDC_BIT_CRS_TX] = crs_tx_en;
    carrier_view[PDC_BIT_MODE_HI:PDC_BIT_MODE_LO] = ds_mode;
    carrier_view[PDC_BIT_ALT_NP] = alt_np;
    carrier_view[PDC_BIT_GROUP] = group_en;
    carrier_view[PDC_BIT_TCLK] = tclk_en;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata <= PDC_ZERO;
    end else if (bus.rd && bus.addr == PDC_ADDR_POWER) begin
      rdata <= power_view;
    end else if (bus.rd && bus.addr == PDC_ADDR_CARRIER) begin
      rdata <= carrier_view;
    end else begin
      rdata <= PDC_ZERO;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      edpd_active <= 1'b0;
      nlp_send <= 1'b0;
    end else begin
      edpd_active <= edpd_en && phy.edpd_cond;
      nlp_send <= edpd_en && phy.edpd_cond && nlp_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      crs_out <= 1'b0;
      group_mode <= 1'b0;
      speed_attempt <= PDC_SPEED_1000;
    end else begin
      crs_out <= crs_tx_en && phy.half_duplex && phy.tx_active;
      group_mode <= group_en;
      speed_attempt <= speed;
    end
  end

  // Register gating keeps the test clock output glitch-free relative to clk sampling.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_clock_out_pin <= 1'b0;
      test_clock_out_en <= 1'b0;
    end else begin
      test_clock_out_pin <= tclk_en && tx_clock;
      test_clock_out_en <= tclk_en;
    end
  end

  pdc_downshift u_downshift (
    .clk(clk),
    .rst_b(rst_b),
    .mode(ds_mode),
    .an_fail(phy.an_fail),
    .link_up(phy.link_up),
    .speed(speed)
  );
endmodule
`default_nettype wire

/* verification/pdc_monitor.sv */
// Port checker for the power-down and downshift control bank.
`timescale 1ns/1ps
`default_nettype none
module pdc_monitor
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire pdc_bus_type bus,
  input wire pdc_phy_in_type phy,
  input wire logic tx_clock,
  input wire logic [15:0] rdata,
  input wire logic edpd_active,
  input wire logic nlp_send,
  input wire logic crs_out,
  input wire logic group_mode,
  input wire logic test_clock_out_pin,
  input wire logic test_clock_out_en,
  input wire pdc_speed_type speed_attempt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_edpd_cause: assert property (edpd_active |-> $past(phy.edpd_cond))
    else $error("edpd");
  chk_nlp_cause: assert property (nlp_send |-> edpd_active && $past(phy.edpd_cond))
    else $error("nlp");
  chk_crs_cause: assert property (crs_out |-> $past(phy.tx_active) && $past(phy.half_duplex))
    else $error("crs");
  chk_drop_restart: assert property ($fell(phy.link_up) |-> ##3 speed_attempt == PDC_SPEED_1000)
    else $error("drop");
  chk_alt_np_read: assert property ($past(bus.rd) && $past(bus.addr) == PDC_ADDR_CARRIER
    |-> rdata[7] == $past(phy.alt_np, 2)) else $error("altnp");
  chk_group_write: assert property ($rose(group_mode) |-> $past(bus.wr, 2)
    && $past(bus.addr, 2) == PDC_ADDR_CARRIER && $past(bus.wdata[6], 2)) else $error("group");
  chk_tclk_gate: assert property (test_clock_out_pin |-> test_clock_out_en && $past(tx_clock))
    else $error("tclk");
  chk_reserved_zero: assert property ($past(bus.rd) && $past(bus.addr) == PDC_ADDR_POWER
    |-> (rdata & 16'hFFF3) == 16'h0000) else $error("rsv");
  chk_carrier_reserved: assert property ($past(bus.rd) && $past(bus.addr) == PDC_ADDR_CARRIER
    |-> (rdata & 16'h731F) == 16'h0000) else $error("rsv carrier");
endmodule
bind pdc_top pdc_monitor i_mon(.clk, .rst_b, .bus, .phy, .tx_clock, .rdata, .edpd_active,
  .nlp_send, .crs_out, .group_mode, .test_clock_out_pin, .test_clock_out_en, .speed_attempt);
`default_nettype wire

/* verification/pdc_station.sv */
// Management station model that issues register cycles.
`timescale 1ns/1ps
`default_nettype none
module pdc_station
  import pdc_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] rdata,
  output var pdc_bus_type bus
);
  initial bus = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    @(posedge clk) d = rdata;
  endtask
  // Changes only the masked bits and writes zeros to reserved positions.
  task automatic rmw(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
    logic [15:0] d;
    rd(a, d);
    wr(a, ((d & ~m) | (v & m)) & (a == PDC_ADDR_POWER ? 16'h000C : 16'h8C60));
  endtask
endmodule
`default_nettype wire

/* verification/tb_phy_power_downshift_control.sv */
// Self-checking bench for the power-down and downshift control bank.
`timescale 1ns/1ps
`default_nettype none
module tb_phy_power_downshift_control;
  import pdc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic tx_clock = 1'b0;
  logic edpd_active, nlp_send, crs_out, group_mode, tp, te;
  logic [15:0] rdata, d;
  pdc_bus_type bus;
  pdc_phy_in_type phy = '0;
  pdc_speed_type sp;
  // Expected speed after each failure: two bits per step, six bits per mode.
  logic [23:0] ex = 24'h251880;
  int fail_count = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  pdc_top i_dut(.clk, .rst_b, .bus, .phy, .tx_clock, .rdata, .edpd_active, .nlp_send, .crs_out,
    .group_mode, .test_clock_out_pin(tp), .test_clock_out_en(te), .speed_attempt(sp));
  pdc_station i_sta(.clk, .rdata, .bus);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(2000);
    fail_count++;
    give_verdict();
  end
  initial begin
    cyc(4);
    rst_b <= 1'b1;
    i_sta.rd(PDC_ADDR_POWER, d);
    chk("pwr", d, 16'h000C);
    i_sta.rd(PDC_ADDR_CARRIER, d);
    chk("ctl", d, 16'h0C00);
    phy.edpd_cond <= 1'b1;
    cyc(4);
    chk("edpd", {14'h0, nlp_send, edpd_active}, 16'h3);
    i_sta.rmw(PDC_ADDR_POWER, 16'h0004, 16'h0000);
    cyc(4);
    chk("nlp", {14'h0, nlp_send, edpd_active}, 16'h1);
    i_sta.wr(PDC_ADDR_POWER, 16'hFFF3);
    i_sta.rd(PDC_ADDR_POWER, d);
    chk("rsv", d, 16'h0000);
    chk("off", {15'h0, edpd_active}, 16'h0);
    i_sta.rd(5'h1F, d);
    chk("unmap", d, 16'h0000);
    phy.tx_active <= 1'b1;
    phy.half_duplex <= 1'b1;
    phy.alt_np <= 1'b1;
    cyc(4);
    chk("crs", {15'h0, crs_out}, 16'h0);
    i_sta.wr(PDC_ADDR_CARRIER, 16'hFFFF);
    i_sta.rd(PDC_ADDR_CARRIER, d);
    chk("ctlw", d, 16'h8CE0);
    chk("outs", {13'h0, crs_out, group_mode, te}, 16'h7);
    tx_clock <= 1'b1;
    cyc(4);
    chk("tclk", {15'h0, tp}, 16'h1);
    i_sta.rmw(PDC_ADDR_CARRIER, 16'h0020, 16'h0000);
    cyc(4);
    chk("tclk0", {14'h0, tp, te}, 16'h0);
    phy.half_duplex <= 1'b0;
    cyc(2);
    chk("crsfd", {15'h0, crs_out}, 16'h0);
    for (int m = 0; m < 4; m++) begin
      phy.link_up <= 1'b1;
      cyc(2);
      phy.link_up <= 1'b0;
      cyc(4);
      chk("drop", {14'h0, sp}, 16'h0);
      i_sta.wr(PDC_ADDR_CARRIER, {4'h0, m[1:0], 10'h000});
      for (int k = 0; k < 3; k++) begin
        phy.an_fail <= 1'b1;
        cyc(1);
        phy.an_fail <= 1'b0;
        cyc(3);
        chk("speed", {14'h0, sp}, {14'h0, ex[m * 6 + k * 2 +: 2]});
      end
    end
    phy.alt_np <= 1'b0;
    i_sta.wr(PDC_ADDR_CARRIER, 16'h0080);
    i_sta.rd(PDC_ADDR_CARRIER, d);
    chk("ronly", d, 16'h0000);
    chk("grp0", {13'h0, crs_out, group_mode, te}, 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
